// file: shared/msr_regs.vh
// Constants for the misc settings and reset status command handler
`ifndef MSR_REGS_VH
`define MSR_REGS_VH
`define MSR_FC_VENDOR      8'h46
`define MSR_FC_EXCEPTION   8'hC6
`define MSR_SF_READ_MISC   8'h29
`define MSR_SF_WRITE_MISC  8'h2A
`define MSR_ADDR_MAX       8'hF7
`define MSR_ADDR_SOFTCFG   8'h00
`define MSR_STATUS_OK      8'h00
`define MSR_STATUS_FAIL    8'h01
`define MSR_EXC_ILL_FUNC   8'h01
`define MSR_EXC_ILL_VALUE  8'h03
`define MSR_EXC_DEV_FAIL   8'h04
`define MSR_FMT_RESET      8'h00
`define MSR_HOST_WDT_US    1000
`define MSR_MOD_WDT_US     10000
`define MSR_CLK_MHZ        100
`endif

// file: hdl/msr_wdog.v
// Generic timeout counter used for host and module watchdogs
`timescale 1ns/10ps
`default_nettype none
module msr_wdog #(
  parameter LIMIT = 1000
) (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  // Control
  input  wire        enable_i,
  input  wire        kick_i,
  // Status
  output reg         expired_o
);
  reg [31:0] cnt_q;
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q     <= 32'h0000_0000;
      expired_o <= 1'b0;
    end else if (ce_i) begin
      if (!enable_i || kick_i) begin
        cnt_q     <= 32'h0000_0000;
        expired_o <= 1'b0;
      end else if (cnt_q >= LIMIT - 1) begin
        expired_o <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 32'h0000_0001;
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/msr_tx.v
// Reply byte serialiser: presents up to four latched bytes in order
`timescale 1ns/10ps
`default_nettype none
module msr_tx (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  // Load side
  input  wire        load_i,
  input  wire [2:0]  len_i,
  input  wire [31:0] bytes_i,
  output wire        busy_o,
  // Byte stream out
  output reg  [7:0]  tx_data_o,
  output wire        tx_valid_o,
  output wire        tx_last_o,
  input  wire        tx_ready_i,
  output wire        done_o
);
  reg [31:0] sh_q;
  reg [2:0]  left_q;
  assign busy_o     = (left_q != 3'h0);
  assign tx_valid_o = busy_o;
  assign tx_last_o  = (left_q == 3'h1);
  assign done_o     = ce_i && tx_valid_o && tx_ready_i && tx_last_o;
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_q      <= 32'h0000_0000;
      left_q    <= 3'h0;
      tx_data_o <= 8'h00;
    end else if (ce_i) begin
      if (load_i && !busy_o) begin
        tx_data_o <= bytes_i[31:24];
        sh_q      <= {bytes_i[23:0], 8'h00};
        left_q    <= len_i;
      end else if (busy_o && tx_ready_i) begin
        tx_data_o <= sh_q[31:24];
        sh_q      <= {sh_q[23:0], 8'h00};
        left_q    <= left_q - 3'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/msr_top.v
// Misc settings read/write handler with config mode, watchdogs and reset status
// What this block does
// RULE_01 - Host reads settings with address 1..247, function 0x46, sub-function 0x29.
// RULE_02 - Read reply echoes address, 0x46, 0x29 then data-format byte.
// RULE_03 - Write 0x2A with one byte; reply echoes then status, 0 is success.
// RULE_04 - Failed settings request answers address, 0xC6 and an exception code.
// RULE_05 - Address selection 0x00 at power-up enters software configuration mode from memory.
// RULE_06 - In software configuration mode switch positions are ignored.
// RULE_07 - Config-set and channel-type commands change address, format and type in that mode; the code ignores them while st_q is ST_INIT or ST_EXEC.
// RULE_08 - A module watchdog resets the module when it stops operating.
// RULE_09 - Host watchdog expiry forces all outputs to their safe state.
// RULE_10 - Reset-status flag set at power-on and on module watchdog reset.
// RULE_11 - Reset-status query reports the flag and clears it after the reply.
// RULE_12 - After module watchdog reset, digital outputs return to power-on values.
// RULE_13 - Frames addressed to another node are ignored without reply.
`include "msr_regs.vh"
`timescale 1ns/10ps
`default_nettype none
module msr_top #(
  parameter HOST_WDT_CYC = `MSR_HOST_WDT_US * `MSR_CLK_MHZ,
  parameter MOD_WDT_CYC  = `MSR_MOD_WDT_US * `MSR_CLK_MHZ
) (
  // Clock, reset, enable
  input  wire        clk_sys_i,
  input  wire        rst_n_i,
  input  wire        ce_i,
  // Received frame bytes, first byte flagged by rx_first_i
  input  wire [7:0]  rx_data_i,
  input  wire        rx_valid_i,
  input  wire        rx_first_i,
  input  wire        rx_end_i,
  // Reply byte stream
  output wire [7:0]  tx_data_o,
  output wire        tx_valid_o,
  output wire        tx_last_o,
  input  wire        tx_ready_i,
  // Switches and non-volatile copy
  input  wire [7:0]  sw_addr_i,
  input  wire [7:0]  sw_fmt_i,
  input  wire [7:0]  sw_type_i,
  input  wire [7:0]  nv_addr_i,
  input  wire [7:0]  nv_fmt_i,
  input  wire [7:0]  nv_type_i,
  output reg         nv_write_o,
  // Software configuration commands
  input  wire        cfg_set_cmd_i,
  input  wire [7:0]  cfg_addr_i,
  input  wire [7:0]  cfg_fmt_i,
  input  wire        chan_type_cmd_i,
  input  wire [7:0]  chan_type_i,
  // Reset status query
  input  wire        rst_query_i,
  output reg         rst_status_o,
  output reg         rst_status_valid_o,
  // Health and outputs
  input  wire        alive_i,
  input  wire [7:0]  dout_req_i,
  input  wire        dout_we_i,
  input  wire [7:0]  dout_poweron_i,
  input  wire [7:0]  dout_safe_i,
  output reg  [7:0]  dout_o,
  output wire        host_wdt_expired_o,
  output wire        mod_wdt_reset_o,
  output reg         soft_cfg_mode_o,
  output reg  [7:0]  cur_addr_o,
  output reg  [7:0]  cur_fmt_o,
  output reg  [7:0]  cur_type_o
);
  localparam ST_INIT = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_FUNC = 3'h2;
  localparam ST_SUB  = 3'h3;
  localparam ST_DATA = 3'h4;
  localparam ST_SKIP = 3'h5;
  localparam ST_EXEC = 3'h6;
  localparam ST_SEND = 3'h7;

  // Format bytes with bit 7 set are not accepted
  function fmt_ok;
    input [7:0] f;
    begin
      fmt_ok = (f[7] == 1'b0);
    end
  endfunction

  // Four-byte normal reply, first byte in the top lane
  function [31:0] pack_ok;
    input [7:0] a;
    input [7:0] sub;
    input [7:0] d;
    begin
      pack_ok = {a, `MSR_FC_VENDOR, sub, d};
    end
  endfunction

  // Three-byte exception reply, bottom lane unused
  function [31:0] pack_exc;
    input [7:0] a;
    input [7:0] code;
    begin
      pack_exc = {a, `MSR_FC_EXCEPTION, code, 8'h00};
    end
  endfunction

  reg  [2:0]  st_q;
  reg  [7:0]  sub_q;
  reg  [7:0]  data_q;
  reg         have_data_q;
  reg         bad_func_q;
  reg         mod_rst_q;
  reg         load_q;
  reg  [2:0]  len_q;
  reg  [31:0] bytes_q;
  wire        mod_rst_evt = mod_wdt_reset_o && !mod_rst_q;
  wire        tx_done;
  wire        rx_take = ce_i && rx_valid_i;

  msr_wdog #(.LIMIT(HOST_WDT_CYC)) u_host_wdt (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .enable_i  (st_q != ST_INIT),
    .kick_i    (rx_valid_i && rx_end_i),
    .expired_o (host_wdt_expired_o)
  );

  msr_wdog #(.LIMIT(MOD_WDT_CYC)) u_mod_wdt (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .enable_i  (!mod_rst_q),
    .kick_i    (alive_i),
    .expired_o (mod_wdt_reset_o)       // RULE_08
  );

  msr_tx u_tx (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .ce_i       (ce_i),
    .load_i     (load_q),
    .len_i      (len_q),
    .bytes_i    (bytes_q),
    .busy_o     (),
    .tx_data_o  (tx_data_o),
    .tx_valid_o (tx_valid_o),
    .tx_last_o  (tx_last_o),
    .tx_ready_i (tx_ready_i),
    .done_o     (tx_done)
  );

  // Outputs, watchdogs and reset status
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dout_o             <= 8'h00;
      mod_rst_q          <= 1'b0;
      rst_status_o       <= 1'b1;
      rst_status_valid_o <= 1'b0;
    end else if (ce_i) begin
      rst_status_valid_o <= 1'b0;
      mod_rst_q          <= mod_wdt_reset_o;
      if (st_q == ST_INIT || mod_rst_evt) begin
        dout_o <= dout_poweron_i;                           // RULE_12
      end else if (host_wdt_expired_o) begin
        dout_o <= dout_safe_i;                              // RULE_09
      end else if (dout_we_i) begin
        dout_o <= dout_req_i;
      end
      if (mod_rst_evt) begin
        rst_status_o <= 1'b1;                               // RULE_10
      end else if (rst_query_i) begin
        rst_status_valid_o <= 1'b1;                         // RULE_11
      end else if (rst_status_valid_o) begin
        rst_status_o <= 1'b0;                               // RULE_11
      end
    end
  end

  // Configuration and frame handling
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q            <= ST_INIT;
      soft_cfg_mode_o <= 1'b0;
      cur_addr_o      <= 8'h00;
      cur_fmt_o       <= `MSR_FMT_RESET;
      cur_type_o      <= 8'h00;
      nv_write_o      <= 1'b0;
      sub_q           <= 8'h00;
      data_q          <= 8'h00;
      have_data_q     <= 1'b0;
      bad_func_q      <= 1'b0;
      load_q          <= 1'b0;
      len_q           <= 3'h0;
      bytes_q         <= 32'h0000_0000;
    end else if (ce_i) begin
      nv_write_o <= 1'b0;
      load_q     <= 1'b0;
      if (mod_rst_evt) begin
        st_q <= ST_INIT;
      end else begin
        case (st_q)
          ST_INIT: begin
            if (sw_addr_i == `MSR_ADDR_SOFTCFG) begin
              soft_cfg_mode_o <= 1'b1;                      // RULE_05
              cur_addr_o      <= nv_addr_i;
              cur_fmt_o       <= nv_fmt_i;
              cur_type_o      <= nv_type_i;
            end else begin
              soft_cfg_mode_o <= 1'b0;
              cur_addr_o      <= sw_addr_i;
              cur_fmt_o       <= sw_fmt_i;
              cur_type_o      <= sw_type_i;
            end
            st_q <= ST_ADDR;
          end
          ST_ADDR: begin
            if (rx_take && rx_first_i) begin
              have_data_q <= 1'b0;
              if (rx_data_i == cur_addr_o && rx_data_i != 8'h00
                  && rx_data_i <= `MSR_ADDR_MAX) begin      // RULE_01
                st_q <= ST_FUNC;
              end else begin
                st_q <= ST_SKIP;                            // RULE_13
              end
            end
          end
          ST_FUNC: begin
            if (rx_take) begin
              bad_func_q <= (rx_data_i != `MSR_FC_VENDOR);
              st_q       <= rx_end_i ? ST_ADDR : ST_SUB;
            end
          end
          ST_SUB: begin
            if (rx_take) begin
              sub_q <= rx_data_i;
              st_q  <= rx_end_i ? ST_EXEC : ST_DATA;
            end
          end
          ST_DATA: begin
            if (rx_take) begin
              if (!have_data_q) begin
                data_q      <= rx_data_i;
                have_data_q <= 1'b1;
              end
              if (rx_end_i) begin
                st_q <= ST_EXEC;
              end
            end
          end
          ST_SKIP: begin
            if (rx_take && rx_end_i) begin
              st_q <= ST_ADDR;
            end
          end
          ST_EXEC: begin
            len_q  <= 3'h4;
            load_q <= 1'b1;
            st_q   <= ST_SEND;
            if (bad_func_q) begin
              len_q   <= 3'h3;                              // RULE_04
              bytes_q <= pack_exc(cur_addr_o, `MSR_EXC_ILL_FUNC);
            end else if (sub_q == `MSR_SF_READ_MISC) begin
              bytes_q <= pack_ok(cur_addr_o, `MSR_SF_READ_MISC, cur_fmt_o); // RULE_02
            end else if (sub_q == `MSR_SF_WRITE_MISC && !have_data_q) begin
              len_q   <= 3'h3;                              // RULE_04
              bytes_q <= pack_exc(cur_addr_o, `MSR_EXC_ILL_VALUE);
            end else if (sub_q == `MSR_SF_WRITE_MISC) begin
              if (fmt_ok(data_q)) begin
                cur_fmt_o  <= data_q;
                nv_write_o <= soft_cfg_mode_o;
                bytes_q <= pack_ok(cur_addr_o, `MSR_SF_WRITE_MISC, `MSR_STATUS_OK); // RULE_03
              end else begin
                bytes_q <= pack_ok(cur_addr_o, `MSR_SF_WRITE_MISC, `MSR_STATUS_FAIL); // RULE_03
              end
            end else begin
              len_q   <= 3'h3;                              // RULE_04
              bytes_q <= pack_exc(cur_addr_o, `MSR_EXC_ILL_FUNC);
            end
          end
          ST_SEND: begin
            if (tx_done) begin
              st_q <= ST_ADDR;
            end
          end
          default: begin
            st_q <= ST_INIT;
          end
        endcase
        // Switches ignored in software mode; these commands (not in ST_INIT or ST_EXEC) and a 0x2A write reconfigure
        if (soft_cfg_mode_o && st_q != ST_INIT && st_q != ST_EXEC) begin // RULE_06
          if (cfg_set_cmd_i) begin
            cur_addr_o <= cfg_addr_i;                       // RULE_07
            cur_fmt_o  <= cfg_fmt_i;
            nv_write_o <= 1'b1;
          end
          if (chan_type_cmd_i) begin
            cur_type_o <= chan_type_i;                      // RULE_07
            nv_write_o <= 1'b1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/msr_checker.sv
// Port-level assertions for the settings and reset status handler
`timescale 1ns/10ps
`default_nettype none
module msr_checker (
  // Clock and reset
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  // Observed ports
  input wire logic       rst_query_i,
  input wire logic       rst_status_o,
  input wire logic       rst_status_valid_o,
  input wire logic       mod_wdt_reset_o,
  input wire logic       host_wdt_expired_o,
  input wire logic [7:0] dout_o,
  input wire logic [7:0] dout_poweron_i,
  input wire logic [7:0] dout_safe_i,
  input wire logic       tx_valid_o,
  input wire logic       tx_last_o,
  input wire logic       tx_ready_i,
  input wire logic [7:0] tx_data_o,
  input wire logic       nv_write_o,
  input wire logic       soft_cfg_mode_o,
  input wire logic       cfg_set_cmd_i,
  input wire logic [7:0] cur_addr_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_ack;
    rst_status_valid_o ##1 (!rst_status_o || mod_wdt_reset_o);
  endsequence
  property p_query; rst_query_i && !mod_wdt_reset_o |=> s_ack; endproperty
  property p_valid; rst_status_valid_o |-> $past(rst_query_i); endproperty
  property p_flag; $rose(mod_wdt_reset_o) |-> ##[0:2] rst_status_o; endproperty
  property p_pwron; $rose(mod_wdt_reset_o) |-> ##[0:2] dout_o == dout_poweron_i; endproperty
  property p_safe; $rose(host_wdt_expired_o) |-> ##[0:1] dout_o == dout_safe_i; endproperty
  property p_hold; tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o); endproperty
  property p_end; tx_valid_o && tx_last_o && tx_ready_i |=> !tx_valid_o; endproperty
  property p_nvw; nv_write_o |-> soft_cfg_mode_o; endproperty
  property p_nocfg; !soft_cfg_mode_o && cfg_set_cmd_i |=> $stable(cur_addr_o); endproperty
  a_query: assert property (p_query) else $error("no status reply");
  a_valid: assert property (p_valid) else $error("status without query");
  a_flag: assert property (p_flag) else $error("flag not set");
  a_pwron: assert property (p_pwron) else $error("outputs not power-on");
  a_safe: assert property (p_safe) else $error("outputs not safe");
  a_hold: assert property (p_hold) else $error("reply byte moved");
  a_end: assert property (p_end) else $error("reply overran");
  a_nvw: assert property (p_nvw) else $error("store outside mode");
  a_nocfg: assert property (p_nocfg) else $error("config changed");
endmodule
bind msr_top msr_checker u_chk (.clk_sys_i, .rst_n_i, .rst_query_i, .rst_status_o,
  .rst_status_valid_o, .mod_wdt_reset_o, .host_wdt_expired_o, .dout_o, .dout_poweron_i,
  .dout_safe_i, .tx_valid_o, .tx_last_o, .tx_ready_i, .tx_data_o, .nv_write_o,
  .soft_cfg_mode_o, .cfg_set_cmd_i, .cur_addr_o);
`default_nettype wire

// file: testbench/msr_host_model.sv
// Host side: accepts reply bytes, optionally stalling
`timescale 1ns/10ps
`default_nettype none
module msr_host_model (
  input wire logic       clk_sys_i,
  input wire logic [7:0] tx_data_i,
  input wire logic       tx_valid_i,
  input wire logic       stall_i,
  output var logic       tx_ready_o
);
  logic [7:0] got[$];
  initial tx_ready_o = 1'b0;
  always @(posedge clk_sys_i) begin
    if (tx_valid_i && tx_ready_o) got.push_back(tx_data_i);
    tx_ready_o <= stall_i ? ~tx_ready_o : 1'b1;
  end
endmodule
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench for the settings and reset status handler
`timescale 1ns/10ps
`default_nettype none
module tb;
  typedef logic [7:0] msr_bq_t[$];
  logic clk_sys_i = 0, rst_n_i = 0, ce_i = 1, rx_valid_i = 0, rx_first_i = 0;
  logic rx_end_i = 0, stall = 0, feed = 1, alive_i = 0, dout_we_i = 0, rst_query_i = 0;
  logic cfg_set_cmd_i = 0, chan_type_cmd_i = 0;
  logic [7:0] rx_data_i = 0, sw_addr_i = 8'h05, sw_fmt_i = 8'h12, sw_type_i = 8'h21;
  logic [7:0] nv_addr_i = 8'h0A, nv_fmt_i = 8'h44, nv_type_i = 8'h09, cfg_addr_i = 0;
  logic [7:0] cfg_fmt_i = 0, chan_type_i = 0, dout_req_i = 0;
  logic [7:0] dout_poweron_i = 8'h81, dout_safe_i = 8'h3C;
  wire logic tx_ready_i, tx_valid_o, tx_last_o, nv_write_o, rst_status_o, rst_status_valid_o;
  wire logic host_wdt_expired_o, mod_wdt_reset_o, soft_cfg_mode_o;
  wire logic [7:0] tx_data_o, dout_o, cur_addr_o, cur_fmt_o, cur_type_o;
  int fails = 0, n_tests = 0;
  msr_bq_t none;
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) alive_i <= feed;
  msr_top #(.HOST_WDT_CYC(400), .MOD_WDT_CYC(200)) uut (.clk_sys_i, .rst_n_i, .ce_i,
    .rx_data_i, .rx_valid_i, .rx_first_i, .rx_end_i, .tx_data_o, .tx_valid_o, .tx_last_o,
    .tx_ready_i, .sw_addr_i, .sw_fmt_i, .sw_type_i, .nv_addr_i, .nv_fmt_i, .nv_type_i,
    .nv_write_o, .cfg_set_cmd_i, .cfg_addr_i, .cfg_fmt_i, .chan_type_cmd_i, .chan_type_i,
    .rst_query_i, .rst_status_o, .rst_status_valid_o, .alive_i, .dout_req_i, .dout_we_i,
    .dout_poweron_i, .dout_safe_i, .dout_o, .host_wdt_expired_o, .mod_wdt_reset_o,
    .soft_cfg_mode_o, .cur_addr_o, .cur_fmt_o, .cur_type_o);
  msr_host_model host (.clk_sys_i, .tx_data_i(tx_data_o), .tx_valid_i(tx_valid_o),
    .stall_i(stall), .tx_ready_o(tx_ready_i));
  task finish_test;
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task limit(input int k, input int n);
    if (k >= n) begin
      fails++;
      finish_test;
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task rst(input logic [7:0] a);
    @(posedge clk_sys_i);
    sw_addr_i <= a;
    rst_n_i <= 0;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1;
    tick(2);
  endtask
  task send(input msr_bq_t b);
    foreach (b[i]) begin
      @(posedge clk_sys_i);
      rx_data_i <= b[i];
      rx_valid_i <= 1;
      rx_first_i <= (i == 0);
      rx_end_i <= (i == b.size() - 1);
    end
    @(posedge clk_sys_i);
    rx_data_i <= ~rx_data_i;
    {rx_valid_i, rx_first_i, rx_end_i} <= 3'h0;
  endtask
  task reply(input msr_bq_t e);
    int k;
    k = 0;
    while (k < 60 && !(e.size() > 0 && host.got.size() == e.size() && !tx_valid_o)) begin
      tick(1);
      k++;
    end
    if (e.size() > 0 && k == 60) begin
      fails++;
      finish_test;
    end
    chk(8'(host.got.size()), 8'(e.size()));
    foreach (e[i]) if (i < host.got.size()) chk(host.got[i], e[i]);
    host.got.delete();
  endtask
  task cfg(input logic [7:0] a, input logic [7:0] f, input logic [7:0] t);
    @(posedge clk_sys_i);
    {cfg_set_cmd_i, chan_type_cmd_i, cfg_addr_i, cfg_fmt_i, chan_type_i} <= {2'h3, a, f, t};
    @(posedge clk_sys_i);
    {cfg_set_cmd_i, chan_type_cmd_i} <= 2'h0;
    tick(2);
  endtask
  task query(input logic e);
    int k;
    @(posedge clk_sys_i);
    rst_query_i <= 1;
    @(posedge clk_sys_i);
    rst_query_i <= 0;
    #1;
    k = 0;
    while (k < 4 && rst_status_valid_o !== 1'b1) begin
      tick(1);
      k++;
    end
    limit(k, 4);
    chk(rst_status_valid_o, 1'b1);
    chk(rst_status_o, e);
  endtask
  task t_read;
    send('{8'h05, 8'h46, 8'h29});
    reply('{8'h05, 8'h46, 8'h29, 8'h12});
    stall = 1;
    send('{8'h05, 8'h46, 8'h29});
    reply('{8'h05, 8'h46, 8'h29, 8'h12});
    stall = 0;
    cfg(8'h0B, 8'h55, 8'h66);
    chk(cur_addr_o, 8'h05);
  endtask
  task t_write;
    send('{8'h05, 8'h46, 8'h2A, 8'h33});
    reply('{8'h05, 8'h46, 8'h2A, 8'h00});
    send('{8'h05, 8'h46, 8'h2A, 8'h80});
    reply('{8'h05, 8'h46, 8'h2A, 8'h01});
    send('{8'h05, 8'h46, 8'h29});
    reply('{8'h05, 8'h46, 8'h29, 8'h33});
  endtask
  task t_exc;
    send('{8'h05, 8'h47, 8'h29});
    reply('{8'h05, 8'hC6, 8'h01});
    send('{8'h05, 8'h46, 8'h55});
    reply('{8'h05, 8'hC6, 8'h01});
    send('{8'h05, 8'h46, 8'h2A});
    reply('{8'h05, 8'hC6, 8'h03});
    @(posedge clk_sys_i);
    ce_i <= 0;
    send('{8'h05, 8'h46, 8'h29});
    reply(none);
    @(posedge clk_sys_i);
    ce_i <= 1;
    send('{8'h06, 8'h46, 8'h29});
    reply(none);
  endtask
  task t_wdog;
    int k;
    @(posedge clk_sys_i);
    {dout_we_i, dout_req_i} <= {1'b1, 8'hA5};
    @(posedge clk_sys_i);
    dout_we_i <= 0;
    tick(2);
    chk(dout_o, 8'hA5);
    k = 0;
    while (k < 500 && host_wdt_expired_o !== 1'b1) begin
      tick(1);
      k++;
    end
    limit(k, 500);
    chk(host_wdt_expired_o, 1'b1);
    tick(1);
    chk(dout_o, 8'h3C);
    send('{8'h05, 8'h46, 8'h29});
    reply('{8'h05, 8'h46, 8'h29, 8'h33});
    feed = 0;
    k = 0;
    while (k < 300 && mod_wdt_reset_o !== 1'b1) begin
      tick(1);
      k++;
    end
    limit(k, 300);
    chk(mod_wdt_reset_o, 1'b1);
    tick(2);
    chk(dout_o, 8'h81);
    chk(rst_status_o, 1'b1);
    feed = 1;
    query(1'b1);
  endtask
  task t_soft;
    rst(8'h00);
    chk(rst_status_o, 1'b1);
    chk(soft_cfg_mode_o, 1'b1);
    chk(cur_addr_o, 8'h0A);
    chk(cur_fmt_o, 8'h44);
    chk(cur_type_o, 8'h09);
    @(posedge clk_sys_i);
    {sw_addr_i, sw_fmt_i} <= {8'h07, 8'h77};
    tick(3);
    chk(cur_addr_o, 8'h0A);
    chk(cur_fmt_o, 8'h44);
    cfg(8'h0B, 8'h55, 8'h66);
    chk(cur_addr_o, 8'h0B);
    chk(cur_fmt_o, 8'h55);
    chk(cur_type_o, 8'h66);
  endtask
  initial begin
    rst(8'h05);
    chk(cur_addr_o, 8'h05);
    t_read;
    t_write;
    t_exc;
    query(1'b1);
    query(1'b0);
    t_wdog;
    t_soft;
    finish_test;
  end
endmodule
`default_nettype wire
